// ==== rtl/flash_regcmd_pkg.sv ====
// constants shared by the register-command interpreter of the serial flash
// assumes one core clock at CLK_MHZ; the host's serial clock is sampled, not used as a clock
// Function
// - lock read takes three address bytes, returns that sector's lock byte.
// - address bits taken on serial clock rise, lock byte driven on falls.
// - raising chip select during output stops the output driver.
// - lock read while a modify cycle runs is rejected, cycle unaffected.
// - lock-down bit freezes both sector bits; cleared only by power-up.
// - write-lock bit blocks program, erase and write on that sector.
// - lock write needs write latch set beforehand by write-unlock.
// - lock write is opcode, three address bytes, one data byte, exact end.
// - lock bits volatile, write latch cleared at once after lock write.
// - lock write during a modify cycle is rejected, nothing changes.
// - flag register readable anytime, repeats while clocked with select low.
// - clear-flags resets the four error bits, needs no write latch.
// - clear-flags leaves the write latch untouched.
// - configuration writes need the write latch set beforehand.
// - persistent config write has two data bytes, exact end at bit sixteen.
// - persistent write starts timed cycle; busy set, then latch cleared.
// - new persistent values act only after the next power-on.
// - in quick power-up state runtime config write needs no write latch.
// - runtime config write has one data byte, exact end at bit eight.
// - runtime config latch clears write latch, takes effect immediately.
package flash_regcmd_pkg;
	localparam int CLK_MHZ           = 250;
	localparam int CMD_BITS          = 8;
	localparam int ADDR_BITS         = 24;
	localparam int LOCK_DATA_BITS    = 8;
	localparam int PERSIST_DATA_BITS = 16;
	localparam int RUNTIME_DATA_BITS = 8;
	localparam int SECTOR_LSB        = 16;

	// lock byte fields
	localparam int LOCK_DOWN_BIT  = 1;
	localparam int LOCK_WRITE_BIT = 0;

	// flag status register fields
	localparam int FLAG_READY_BIT = 7;
	localparam int FLAG_ERASE_BIT = 5;
	localparam int FLAG_PROG_BIT  = 4;
	localparam int FLAG_VPP_BIT   = 3;
	localparam int FLAG_PROT_BIT  = 1;

	// error flags are kept packed in this order
	localparam int ERR_ERASE = 3;
	localparam int ERR_PROG  = 2;
	localparam int ERR_VPP   = 1;
	localparam int ERR_PROT  = 0;

	localparam logic [1:0]  LOCK_RESET    = 2'h0;
	localparam logic [3:0]  ERR_RESET     = 4'h0;
	localparam logic [15:0] PERSIST_RESET = 16'hffff;
	localparam logic [7:0]  RUNTIME_RESET = 8'hfb;
	// idle pin levels {select high, clock low, data high}, so no false edge after reset
	localparam logic [2:0]  PIN_IDLE      = 3'h5;

	typedef enum logic [2:0] {
		ph_cmd,
		ph_addr,
		ph_data_in,
		ph_data_out,
		ph_ignore
	} phase_e;

	typedef enum logic [3:0] {
		op_none,
		op_rd_lock,
		op_wr_lock,
		op_rd_flag,
		op_clr_flag,
		op_unlock,
		op_rd_persist,
		op_wr_persist,
		op_rd_runtime,
		op_wr_runtime
	} op_e;
endpackage

// ==== rtl/spi_link_if.sv ====
// sampled serial link events passed from the pin front end to the interpreter
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface spi_link_if;
	logic sck_rise;
	logic sck_fall;
	logic sel;
	logic sel_start;
	logic sel_end;
	logic din;

	modport front (output sck_rise, output sck_fall, output sel, output sel_start,
		output sel_end, output din);
	modport core (input sck_rise, input sck_fall, input sel, input sel_start,
		input sel_end, input din);
endinterface

// ==== rtl/spi_pin_front.sv ====
// pin synchronisers and edge finder for chip select, serial clock and data in
// assumes the serial clock is well below a quarter of sys_clk
`timescale 1ns/100ps
module spi_pin_front
	import flash_regcmd_pkg::*;
(
	input  wire logic   sys_clk,
	input  wire logic   rst,
	input  wire logic   cs_n_pin,
	input  wire logic   sclk_pin,
	input  wire logic   din_pin,
	spi_link_if.front   link
);
	logic [2:0] meta_ff;
	logic [2:0] sync_ff;
	logic [2:0] prev_ff;

	// *****************************************
	// two-stage synchronisers, then one history stage
	// *****************************************
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_ff <= PIN_IDLE;
			sync_ff <= PIN_IDLE;
			prev_ff <= PIN_IDLE;
		end
		else
		begin
			meta_ff <= {cs_n_pin, sclk_pin, din_pin};
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// edges only count while selected, so stray clocks between frames are ignored
	assign link.sel       = ~sync_ff[2];
	assign link.sel_start = ~sync_ff[2] & prev_ff[2];
	assign link.sel_end   = sync_ff[2] & ~prev_ff[2];
	assign link.sck_rise  = ~sync_ff[2] & sync_ff[1] & ~prev_ff[1];
	assign link.sck_fall  = ~sync_ff[2] & ~sync_ff[1] & prev_ff[1];
	assign link.din       = sync_ff[0];
endmodule

// ==== rtl/flash_regcmd.sv ====
// register-command interpreter: sector locks, flag status, config registers
// assumes modify_busy and err_set come from the array controller on sys_clk
`timescale 1ns/100ps
module flash_regcmd
	import flash_regcmd_pkg::*;
#(
	parameter int         NUM_SECTORS      = 256,
	parameter int         SECT_W           = 8,
	parameter int         PERSIST_TIME_US  = 200,
	parameter int         PERSIST_CYCLES   = PERSIST_TIME_US * CLK_MHZ,
	parameter logic [7:0] RD_LOCK_OPC      = 8'h10,
	parameter logic [7:0] WR_LOCK_OPC      = 8'h11,
	parameter logic [7:0] RD_FLAG_OPC      = 8'h12,
	parameter logic [7:0] CLR_FLAG_OPC     = 8'h13,
	parameter logic [7:0] UNLOCK_OPC       = 8'h14,
	parameter logic [7:0] RD_PERSIST_OPC   = 8'h15,
	parameter logic [7:0] WR_PERSIST_OPC   = 8'h16,
	parameter logic [7:0] RD_RUNTIME_OPC   = 8'h17,
	parameter logic [7:0] WR_RUNTIME_OPC   = 8'h18
)
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              cs_n_pin,
	input  wire logic              sclk_pin,
	input  wire logic              serial_in_line,
	output logic                   serial_out_line,
	output logic                   serial_out_oe,
	input  wire logic              modify_busy,
	input  wire logic [3:0]        err_set,
	input  wire logic              quick_powerup_enter,
	input  wire logic [SECT_W-1:0] query_sector,
	output logic                   query_locked,
	output logic                   write_latch_flag,
	output logic                   busy_flag,
	output logic                   quick_powerup,
	output logic [15:0]            persist_cfg_active,
	output logic [7:0]             runtime_cfg
);
	spi_link_if link ();

	spi_pin_front u_front
	(
		.sys_clk  (sys_clk),
		.rst      (rst),
		.cs_n_pin (cs_n_pin),
		.sclk_pin (sclk_pin),
		.din_pin  (serial_in_line),
		.link     (link.front)
	);

	localparam int CNT_W = $clog2(PERSIST_CYCLES + 1);

	phase_e              phase_ff;
	op_e                 op_ff;
	logic [5:0]          bit_cnt_ff;
	logic [23:0]         in_sr_ff;
	logic [5:0]          data_cnt_ff;
	logic [SECT_W-1:0]   sect_ff;
	logic [15:0]         out_sr_ff;
	logic                out_ff;
	logic                oe_ff;
	logic [1:0]          lock_ff [NUM_SECTORS];
	logic                latch_ff;
	logic                quick_ff;
	logic [3:0]          err_ff;
	logic [15:0]         persist_store_ff;
	logic [15:0]         persist_active_ff;
	logic                cfg_loaded_ff;
	logic [7:0]          runtime_ff;
	logic                nv_busy_ff;
	logic [CNT_W-1:0]    nv_cnt_ff;
	logic                busy_out_ff;
	logic                query_ff;
	logic                busy;
	logic [7:0]          opcode;
	logic [7:0]          flag_byte;
	logic                exact_end;
	logic                go_wr_lock;
	logic                go_clr_flag;
	logic                go_unlock;
	logic                go_wr_persist;
	logic                go_wr_runtime;
	logic                nv_done;
	op_e                 nxt_op;

	// *****************************************
	// decode helpers
	// *****************************************
	assign busy      = nv_busy_ff | modify_busy;
	assign opcode    = {in_sr_ff[6:0], link.din};
	assign nv_done   = nv_busy_ff && (nv_cnt_ff == CNT_W'(1));

	// flag byte: ready is the inverse of busy, errors in their slots
	always_comb
	begin
		flag_byte                 = 8'h00;
		flag_byte[FLAG_READY_BIT] = ~busy;
		flag_byte[FLAG_ERASE_BIT] = err_ff[ERR_ERASE];
		flag_byte[FLAG_PROG_BIT]  = err_ff[ERR_PROG];
		flag_byte[FLAG_VPP_BIT]   = err_ff[ERR_VPP];
		flag_byte[FLAG_PROT_BIT]  = err_ff[ERR_PROT];
	end

	// opcode table lookup on the eighth instruction bit
	always_comb
	begin
		nxt_op = op_none;
		case (opcode)
			RD_LOCK_OPC:    nxt_op = op_rd_lock;
			WR_LOCK_OPC:    nxt_op = op_wr_lock;
			RD_FLAG_OPC:    nxt_op = op_rd_flag;
			CLR_FLAG_OPC:   nxt_op = op_clr_flag;
			UNLOCK_OPC:     nxt_op = op_unlock;
			RD_PERSIST_OPC: nxt_op = op_rd_persist;
			WR_PERSIST_OPC: nxt_op = op_wr_persist;
			RD_RUNTIME_OPC: nxt_op = op_rd_runtime;
			WR_RUNTIME_OPC: nxt_op = op_wr_runtime;
			default:        nxt_op = op_none;
		endcase
	end

	// a write runs only when select rises exactly after its last data bit
	always_comb
	begin
		exact_end = 1'b0;
		case (op_ff)
			op_wr_lock:    exact_end = (data_cnt_ff == 6'(LOCK_DATA_BITS));
			op_wr_persist: exact_end = (data_cnt_ff == 6'(PERSIST_DATA_BITS));
			op_wr_runtime: exact_end = (data_cnt_ff == 6'(RUNTIME_DATA_BITS));
			op_clr_flag:   exact_end = (data_cnt_ff == 6'h00);
			op_unlock:     exact_end = (data_cnt_ff == 6'h00);
			default:       exact_end = 1'b0;
		endcase
	end

	// execution strobes, all at the rise of chip select
	always_comb
	begin
		go_wr_lock    = 1'b0;
		go_clr_flag   = 1'b0;
		go_unlock     = 1'b0;
		go_wr_persist = 1'b0;
		go_wr_runtime = 1'b0;
		if (link.sel_end && phase_ff == ph_data_in && exact_end)
		begin
			go_wr_lock    = (op_ff == op_wr_lock) && latch_ff && !busy;
			go_clr_flag   = (op_ff == op_clr_flag);
			go_unlock     = (op_ff == op_unlock) && !busy;
			go_wr_persist = (op_ff == op_wr_persist) && latch_ff && !busy;
			go_wr_runtime = (op_ff == op_wr_runtime) && !busy
				&& (latch_ff || quick_ff);
		end
	end

	// *****************************************
	// serial framing
	// *****************************************
	// phase machine: instruction, address, data in or data out
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			phase_ff    <= ph_cmd;
			op_ff       <= op_none;
			bit_cnt_ff  <= 6'h00;
			data_cnt_ff <= 6'h00;
		end
		else if (!link.sel || link.sel_start)
		begin
			phase_ff    <= ph_cmd;
			op_ff       <= op_none;
			bit_cnt_ff  <= 6'h00;
			data_cnt_ff <= 6'h00;
		end
		else if (link.sck_rise)
		begin
			case (phase_ff)
				ph_cmd:
				begin
					bit_cnt_ff <= bit_cnt_ff + 6'h01;
					if (bit_cnt_ff == 6'(CMD_BITS - 1))
					begin
						bit_cnt_ff <= 6'h00;
						op_ff      <= nxt_op;
						case (nxt_op)
							op_rd_lock:    phase_ff <= busy ? ph_ignore : ph_addr;
							op_wr_lock:    phase_ff <= ph_addr;
							op_rd_flag:    phase_ff <= ph_data_out;
							op_rd_persist: phase_ff <= ph_data_out;
							op_rd_runtime: phase_ff <= ph_data_out;
							op_none:       phase_ff <= ph_ignore;
							default:       phase_ff <= ph_data_in;
						endcase
					end
				end
				ph_addr:
				begin
					bit_cnt_ff <= bit_cnt_ff + 6'h01;
					if (bit_cnt_ff == 6'(ADDR_BITS - 1))
						phase_ff <= (op_ff == op_rd_lock) ? ph_data_out : ph_data_in;
				end
				ph_data_in:
				begin
					// saturate so an overlong frame never wraps back to exact
					if (data_cnt_ff != 6'h3f)
						data_cnt_ff <= data_cnt_ff + 6'h01;
				end
				default:
				begin
					phase_ff <= phase_ff;
				end
			endcase
		end
	end

	// input shift register, address bits latched on serial clock rise
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			in_sr_ff <= 24'h000000;
		else if (link.sck_rise)
			in_sr_ff <= {in_sr_ff[22:0], link.din};
	end

	// sector index taken from the completed address, any byte in the sector
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			sect_ff <= '0;
		else if (link.sck_rise && phase_ff == ph_addr && bit_cnt_ff == 6'(ADDR_BITS - 1))
			sect_ff <= in_sr_ff[SECTOR_LSB-1 +: SECT_W];
	end

	// output word loaded on entry to data out, then rotated so reads repeat
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			out_sr_ff <= 16'h0000;
		else if (link.sck_rise && phase_ff == ph_cmd && bit_cnt_ff == 6'(CMD_BITS - 1))
		begin
			case (nxt_op)
				op_rd_flag:    out_sr_ff <= {flag_byte, flag_byte};
				op_rd_persist: out_sr_ff <= persist_store_ff;
				op_rd_runtime: out_sr_ff <= {runtime_ff, runtime_ff};
				default:       out_sr_ff <= out_sr_ff;
			endcase
		end
		else if (link.sck_rise && phase_ff == ph_addr && bit_cnt_ff == 6'(ADDR_BITS - 1))
			out_sr_ff <= {6'h00, lock_ff[in_sr_ff[SECTOR_LSB-1 +: SECT_W]],
				6'h00, lock_ff[in_sr_ff[SECTOR_LSB-1 +: SECT_W]]};
		else if (link.sck_fall && phase_ff == ph_data_out)
			out_sr_ff <= {out_sr_ff[14:0], out_sr_ff[15]};
	end

	// output pin and its enable; released as soon as select goes high
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			out_ff <= 1'b0;
			oe_ff  <= 1'b0;
		end
		else if (!link.sel)
		begin
			out_ff <= 1'b0;
			oe_ff  <= 1'b0;
		end
		else if (link.sck_fall && phase_ff == ph_data_out)
		begin
			out_ff <= out_sr_ff[15];
			oe_ff  <= 1'b1;
		end
	end

	// *****************************************
	// registers
	// *****************************************
	// one lock pair per sector; lock-down freezes both bits until reset
	generate
		for (genvar g = 0; g < NUM_SECTORS; g++)
		begin : g_lock
			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
					lock_ff[g] <= LOCK_RESET;
				else if (go_wr_lock && sect_ff == SECT_W'(g) && !lock_ff[g][LOCK_DOWN_BIT])
					lock_ff[g] <= in_sr_ff[1:0];
			end
		end
	endgenerate

	// array side asks whether a sector may be modified
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			query_ff <= 1'b0;
		else
			query_ff <= lock_ff[query_sector][LOCK_WRITE_BIT];
	end

	// write latch: set by unlock, cleared by completed writes only
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			latch_ff <= 1'b0;
		else if (go_unlock)
			latch_ff <= 1'b1;
		else if (go_wr_lock || go_wr_runtime || nv_done)
			latch_ff <= 1'b0;
	end

	// quick power-up state, left by any accepted unlock
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			quick_ff <= 1'b0;
		else if (go_unlock)
			quick_ff <= 1'b0;
		else if (quick_powerup_enter)
			quick_ff <= 1'b1;
	end

	// error flags: a new error in the clearing cycle survives
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			err_ff <= ERR_RESET;
		else
			err_ff <= (go_clr_flag ? ERR_RESET : err_ff) | err_set;
	end

	// persistent store and its self-timed update cycle
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			persist_store_ff <= PERSIST_RESET;
			nv_busy_ff       <= 1'b0;
			nv_cnt_ff        <= '0;
		end
		else if (go_wr_persist)
		begin
			persist_store_ff <= in_sr_ff[15:0];
			nv_busy_ff       <= 1'b1;
			nv_cnt_ff        <= CNT_W'(PERSIST_CYCLES);
		end
		else if (nv_busy_ff)
		begin
			nv_cnt_ff  <= nv_cnt_ff - CNT_W'(1);
			nv_busy_ff <= !nv_done;
		end
	end

	// active copy is taken once after reset, so new values wait for power-on
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			persist_active_ff <= PERSIST_RESET;
			cfg_loaded_ff     <= 1'b0;
		end
		else if (!cfg_loaded_ff)
		begin
			persist_active_ff <= persist_store_ff;
			cfg_loaded_ff     <= 1'b1;
		end
	end

	// runtime config acts straight away
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			runtime_ff <= RUNTIME_RESET;
		else if (go_wr_runtime)
			runtime_ff <= in_sr_ff[7:0];
	end

	// registered busy for the outside world
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			busy_out_ff <= 1'b0;
		else
			busy_out_ff <= busy;
	end

	assign serial_out_line    = out_ff;
	assign serial_out_oe      = oe_ff;
	assign query_locked       = query_ff;
	assign write_latch_flag   = latch_ff;
	assign busy_flag          = busy_out_ff;
	assign quick_powerup      = quick_ff;
	assign persist_cfg_active = persist_active_ff;
	assign runtime_cfg        = runtime_ff;
endmodule

// ==== tb/flash_regcmd_chk.sv ====
// checker for the register-command interpreter, bound to its top ports
// assumes one core clock and the async active-high reset of the design
`timescale 1ns/100ps
module flash_regcmd_chk
#(
	parameter int SECT_W = 8
)
(
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire logic              cs_n_pin,
	input wire logic              serial_out_oe,
	input wire logic              modify_busy,
	input wire logic [SECT_W-1:0] query_sector,
	input wire logic              query_locked,
	input wire logic              write_latch_flag,
	input wire logic              busy_flag,
	input wire logic [15:0]       persist_cfg_active,
	input wire logic [7:0]        runtime_cfg
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ****************************************
	// properties
	// ****************************************
	// select seen high long enough: sync delay is 3 to 4 cycles
	a_oe_idle_off: assert property (cs_n_pin [*7] |-> !serial_out_oe)
		else $error("output still driven while deselected");
	a_busy_follows: assert property (modify_busy |=> busy_flag)
		else $error("busy flag missed a modify cycle");
	a_latch_rise_idle: assert property ($rose(write_latch_flag) |->
		$past(cs_n_pin) && $past(cs_n_pin, 2))
		else $error("write latch set inside a frame");
	// query result moves one cycle after the sector, so skip sector changes
	a_lock_busy_hold: assert property ((modify_busy [*8] ##1 modify_busy) |->
		$stable(query_locked) || ($past(query_sector) != $past(query_sector, 2)))
		else $error("lock bit changed during a modify cycle");
	a_lock_latch_clr: assert property (($changed(query_locked) &&
		$past(query_sector) == $past(query_sector, 2)) |-> !write_latch_flag)
		else $error("latch still set after lock update");
	a_nv_done_latch: assert property (($fell(busy_flag) && !$past(modify_busy, 2)) |->
		##[0:1] !write_latch_flag)
		else $error("latch kept after persistent update");
	a_persist_frozen: assert property (!$past(rst) |-> $stable(persist_cfg_active))
		else $error("persistent config changed before power-up");
	a_runtime_latch: assert property ($changed(runtime_cfg) |-> !write_latch_flag)
		else $error("latch kept after runtime config write");
	c_read_out: cover property ($rose(serial_out_oe));
	c_nv_done: cover property ($fell(busy_flag));
	c_rt_write: cover property ($changed(runtime_cfg));
endmodule

bind flash_regcmd flash_regcmd_chk #(.SECT_W(SECT_W)) u_flash_regcmd_chk
(
	.sys_clk            (sys_clk),
	.rst                (rst),
	.cs_n_pin           (cs_n_pin),
	.serial_out_oe      (serial_out_oe),
	.modify_busy        (modify_busy),
	.query_sector       (query_sector),
	.query_locked       (query_locked),
	.write_latch_flag   (write_latch_flag),
	.busy_flag          (busy_flag),
	.persist_cfg_active (persist_cfg_active),
	.runtime_cfg        (runtime_cfg)
);

// ==== tb/spi_host_model.sv ====
// host side of the serial link: select, clock and data in, whole frames
// assumes sys_clk at 4 ns; serial clock stands low between frames
`timescale 1ns/100ps
module spi_host_model
(
	input  wire logic sys_clk,
	input  wire logic miso,
	output logic      cs_n,
	output logic      sclk,
	output logic      din
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b0;
	end
	// ****************************************
	// frame driver
	// ****************************************
	// half of the 80 ns serial period
	task automatic half;
		repeat (10) @(posedge sys_clk);
	endtask
	// tx is left-justified; reads sample on the rise, device shifts on falls
	task automatic xfer(input logic [47:0] tx, input int ntx, input int nrx,
		output logic [15:0] rx);
		int i;
		rx = 16'h0000;
		cs_n <= 1'b0;
		half();
		for (i = 0; i < ntx; i++)
		begin
			din <= tx[47-i]; // msb first
			half();
			sclk <= 1'b1;
			half();
			sclk <= 1'b0;
		end
		for (i = 0; i < nrx; i++)
		begin
			din <= ~din; // ignored by the device, kept moving
			half();
			sclk <= 1'b1;
			rx = {rx[14:0], miso};
			half();
			sclk <= 1'b0;
		end
		half();
		cs_n <= 1'b1; // release right after the last bit
		din  <= ~din;
		half();
	endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the register-command interpreter
// assumes default opcodes 8'h10..8'h18 and a shortened persistent update
`timescale 1ns/100ps
module testbench
	import flash_regcmd_pkg::*;
;
	localparam logic [7:0] RDL = 8'h10, WRL = 8'h11, RDF = 8'h12, CLF = 8'h13, UNL = 8'h14;
	localparam logic [7:0] RDP = 8'h15, WRP = 8'h16, RDR = 8'h17, WRR = 8'h18;
	logic        sys_clk, rst, modify_busy, quick_powerup_enter, cs_n, sclk, din;
	logic        serial_out_line, serial_out_oe, query_locked, write_latch_flag;
	logic        busy_flag, quick_powerup, miso;
	logic        last_out = 1'b0;
	logic [3:0]  err_set;
	logic [7:0]  query_sector, sec, d, v;
	logic [15:0] rv, pv;
	logic [31:0] rnd;
	logic [15:0] persist_cfg_active;
	logic [7:0]  runtime_cfg;
	int          seed = 32'hed501bd1;
	int          checks, miscompares, cycles, oe_cnt, o, i;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
	flash_regcmd #(.PERSIST_CYCLES(20)) u_flash_regcmd
	(
		.sys_clk             (sys_clk),
		.rst                 (rst),
		.cs_n_pin            (cs_n),
		.sclk_pin            (sclk),
		.serial_in_line      (din),
		.serial_out_line     (serial_out_line),
		.serial_out_oe       (serial_out_oe),
		.modify_busy         (modify_busy),
		.err_set             (err_set),
		.quick_powerup_enter (quick_powerup_enter),
		.query_sector        (query_sector),
		.query_locked        (query_locked),
		.write_latch_flag    (write_latch_flag),
		.busy_flag           (busy_flag),
		.quick_powerup       (quick_powerup),
		.persist_cfg_active  (persist_cfg_active),
		.runtime_cfg         (runtime_cfg)
	);
	spi_host_model u_spi_host_model
	(
		.sys_clk (sys_clk),
		.miso    (miso),
		.cs_n    (cs_n),
		.sclk    (sclk),
		.din     (din)
	);
	// ****************************************
	// clock, undriven line, watchdog
	// ****************************************
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// released line shows the inverse of its last value, no pull
	assign miso = serial_out_oe ? serial_out_line : ~last_out;
	always @(posedge sys_clk)
	begin
		if (serial_out_oe === 1'b1)
		begin
			last_out <= serial_out_line;
			oe_cnt++;
		end
		cycles++;
		if (cycles == 60000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] flag_byte(input logic rdy, input logic [3:0] e);
		return {rdy, 1'b0, e[3], e[2], e[1], 1'b0, e[0], 1'b0};
	endfunction
	task automatic go(input logic [7:0] opc, input logic [39:0] pay, input int nb, input int nr);
		u_spi_host_model.xfer({opc, pay}, 8 + nb, nr, rv);
	endtask
	task automatic qry(input logic [7:0] s, input logic e);
		query_sector <= s;
		repeat (3) @(posedge sys_clk);
		`CHK(query_locked, e)
	endtask
	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		rst = 1'b1;
		modify_busy = 1'b0;
		err_set = 4'h0;
		quick_powerup_enter = 1'b0;
		query_sector = 8'h00;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK(runtime_cfg, RUNTIME_RESET)
		`CHK(persist_cfg_active, PERSIST_RESET)
		// lock write with no latch is dropped
		go(WRL, {8'h20, 16'h1234, 8'h01, 8'h00}, 32, 0);
		qry(8'h20, 1'b0);
		// random sectors and write-lock values, below the lock-down test sectors 8'hfe and 8'hff
		for (i = 0; i < 3; i++)
		begin
			rnd = $random(seed);
			sec = {1'b0, rnd[30:24]};
			d = {6'h00, 1'b0, rnd[0]}; // upper bits zero
			go(UNL, 40'h0, 0, 0);
			`CHK(write_latch_flag, 1'b1)
			go(WRL, {sec, rnd[15:0], d, 8'h00}, 32, 0);
			`CHK(write_latch_flag, 1'b0)
			qry(sec, d[0]);
			go(RDL, {sec, rnd[23:8], 16'h0000}, 24, 8);
			`CHK(rv[7:0], d)
		end
		// lock-down freezes the sector
		go(UNL, 40'h0, 0, 0);
		go(WRL, {8'hff, 16'h0000, 8'h03, 8'h00}, 32, 0);
		go(UNL, 40'h0, 0, 0);
		go(WRL, {8'hff, 16'hffff, 8'h00, 8'h00}, 32, 0);
		`CHK(write_latch_flag, 1'b0)
		go(RDL, {8'hff, 16'h8000, 16'h0000}, 24, 8);
		`CHK(rv[7:0], 8'h03)
		// early release during output
		go(RDL, {8'hff, 32'h0}, 24, 3);
		`CHK(serial_out_oe, 1'b0)
		// one data bit short: not executed, latch kept; seven bits end in a one
		go(UNL, 40'h0, 0, 0);
		go(WRL, {8'hfe, 16'h0000, 8'h02, 8'h00}, 31, 0);
		qry(8'hfe, 1'b0);
		// modify cycle running: lock commands refused, flags readable
		modify_busy <= 1'b1;
		err_set <= 4'hf;
		@(posedge sys_clk);
		err_set <= 4'h0;
		repeat (10) @(posedge sys_clk);
		go(WRL, {8'hfe, 16'h0000, 8'h01, 8'h00}, 32, 0);
		o = oe_cnt;
		go(RDL, {8'hfe, 32'h0}, 24, 8);
		`CHK(oe_cnt, o)
		go(RDF, 40'h0, 0, 16);
		`CHK(rv, {2{flag_byte(1'b0, 4'hf)}})
		modify_busy <= 1'b0;
		qry(8'hfe, 1'b0);
		go(CLF, 40'h0, 0, 0);
		`CHK(write_latch_flag, 1'b1)
		go(RDF, 40'h0, 0, 8);
		`CHK(rv[7:0], flag_byte(1'b1, 4'h0))
		// runtime config: with latch, without, quick state, overlong frame
		rnd = $random(seed);
		go(WRR, {rnd[7:0], 32'h0}, 8, 0);
		`CHK(runtime_cfg, rnd[7:0])
		`CHK(write_latch_flag, 1'b0)
		go(WRR, {~rnd[7:0], 32'h0}, 8, 0);
		`CHK(runtime_cfg, rnd[7:0])
		quick_powerup_enter <= 1'b1;
		@(posedge sys_clk);
		quick_powerup_enter <= 1'b0;
		go(WRR, {8'h5a, 32'h0}, 8, 0);
		`CHK(runtime_cfg, 8'h5a)
		`CHK(quick_powerup, 1'b1)
		go(WRR, {8'ha5, 32'h0}, 9, 0);
		go(RDR, 40'h0, 0, 8);
		`CHK(rv[7:0], 8'h5a)
		// persistent config: timed update, active copy stays
		pv = rnd[31:16];
		go(UNL, 40'h0, 0, 0);
		`CHK(quick_powerup, 1'b0)
		go(WRP, {pv, 24'h0}, 16, 0);
		`CHK(busy_flag, 1'b1)
		go(RDF, 40'h0, 0, 8); // poll ready first
		`CHK(rv[7], 1'b1)
		`CHK(write_latch_flag, 1'b0)
		go(RDP, 40'h0, 0, 16);
		`CHK(rv, pv)
		`CHK(persist_cfg_active, PERSIST_RESET)
		tally_and_finish();
	end
endmodule
